// ---- src/twlsg_pkg.sv ----
// package: opcodes, signal codes, timing and state types for the line signal generator
package twlsg_pkg;
  localparam logic [7:0] TWLSG_OPCODE      = 8'h18; // line_signal_command opcode
  localparam logic [7:0] TWLSG_SIG_INIT    = 8'h00;
  localparam logic [7:0] TWLSG_SIG_START   = 8'h01;
  localparam logic [7:0] TWLSG_SIG_STOP    = 8'h02;
  localparam logic [7:0] TWLSG_SIG_BOTH_LO = 8'h03;
  localparam logic [7:0] TWLSG_SIG_BOTH_HI = 8'h04;
  localparam logic [7:0] TWLSG_SIG_DAT_HI  = 8'h05;
  localparam logic [7:0] TWLSG_SIG_DAT_LO  = 8'h06;
  localparam logic [7:0] TWLSG_SIG_CLK_HI  = 8'h07;
  localparam logic [7:0] TWLSG_SIG_CLK_LO  = 8'h08;
  localparam logic [7:0] TWLSG_SIG_RD_DAT  = 8'h09;
  localparam logic [7:0] TWLSG_SIG_RD_CLK  = 8'h0a;
  // hold time of each line step, in ns, and its cycle count at 100 MHz
  localparam int         TWLSG_CLK_PERIOD_NS = 10;
  localparam int         TWLSG_STEP_HOLD_NS  = 5000;
  localparam int         TWLSG_STEP_CYCLES   = (TWLSG_STEP_HOLD_NS + TWLSG_CLK_PERIOD_NS - 1) / TWLSG_CLK_PERIOD_NS;
  localparam int         TWLSG_CNT_W         = 16;
  localparam logic [TWLSG_CNT_W-1:0] TWLSG_CNT_RST = 16'h0000;
  localparam logic [2:0] TWLSG_STEP_RST      = 3'h0;
  // one step of a pattern: which line, and release (1) or drive low (0)
  typedef struct packed {
    logic       valid;
    logic       is_clk;
    logic       level;
  } twlsg_step_t;
  typedef enum logic [1:0] {
    TWLSG_IDLE = 2'b00,
    TWLSG_RUN  = 2'b01,
    TWLSG_HOLD = 2'b11,
    TWLSG_DONE = 2'b10
  } twlsg_state_t;
endpackage

// ---- src/twlsg_sync.sv ----
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ns
`default_nettype none
module twlsg_sync
(
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_pin,
  output logic      o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } twlsg_sync_t;
  twlsg_sync_t st_reg;
  twlsg_sync_t st_next;
  // shift the pin in; accept a change once stages two and three agree
  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = i_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.lvl = st_reg.s3;
    end
  end
  // idle bus reads high through the pull-up
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      st_reg <= 4'hf;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  assign o_level = st_reg.lvl;
endmodule
`default_nettype wire

// ---- src/twlsg_top.sv ----
// line signal generator: runs two-wire line patterns on command and answers
`timescale 1ns/1ns
`default_nettype none
module twlsg_top
  import twlsg_pkg::*;
#(
  parameter int P_STEP_CYCLES = TWLSG_STEP_CYCLES
)
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_opcode,
  input  wire logic [7:0] i_cmd_signal,
  output logic            o_cmd_ready,
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_opcode,
  output logic [7:0]      o_rsp_data,
  output logic            o_cmd_reject,
  input  wire logic       i_serial_data_pin,
  output logic            o_serial_data_pin,
  output logic            o_serial_data_pin_oe_n,
  input  wire logic       i_serial_clock_pin,
  output logic            o_serial_clock_pin,
  output logic            o_serial_clock_pin_oe_n
);
  typedef struct packed {
    twlsg_state_t            state;
    logic [7:0]              sig;
    logic [2:0]              step;
    logic [TWLSG_CNT_W-1:0]  cnt;
    logic                    dat_rel;
    logic                    clk_rel;
    logic                    ready;
    logic                    rsp_valid;
    logic [7:0]              rsp_opcode;
    logic [7:0]              rsp_data;
    logic                    reject;
  } twlsg_regs_t;

  localparam logic [TWLSG_CNT_W-1:0] HOLD_LAST = TWLSG_CNT_W'(P_STEP_CYCLES - 1);

  twlsg_regs_t st_reg;
  twlsg_regs_t st_next;
  logic        dat_level;
  logic        clk_level;

  // synchronised line levels as seen on the bus
  twlsg_sync u_dat_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_serial_data_pin),
    .o_level   (dat_level)
  );
  twlsg_sync u_clk_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_serial_clock_pin),
    .o_level   (clk_level)
  );

  // pattern table: step n of a signal type
  function automatic twlsg_step_t step_of(input logic [7:0] sig, input logic [2:0] n);
    twlsg_step_t s;
    s = 3'h0;
    unique case (sig)
      TWLSG_SIG_INIT, TWLSG_SIG_BOTH_HI:
      begin
        if (n == 3'h0) s = '{1'b1, 1'b0, 1'b1};
        if (n == 3'h1) s = '{1'b1, 1'b1, 1'b1};
      end
      TWLSG_SIG_START:
      begin
        if (n == 3'h0) s = '{1'b1, 1'b0, 1'b1};
        if (n == 3'h1) s = '{1'b1, 1'b1, 1'b1};
        if (n == 3'h2) s = '{1'b1, 1'b0, 1'b0};
        if (n == 3'h3) s = '{1'b1, 1'b1, 1'b0};
      end
      TWLSG_SIG_STOP:
      begin
        if (n == 3'h0) s = '{1'b1, 1'b0, 1'b0};
        if (n == 3'h1) s = '{1'b1, 1'b1, 1'b1};
        if (n == 3'h2) s = '{1'b1, 1'b0, 1'b1};
      end
      TWLSG_SIG_BOTH_LO:
      begin
        if (n == 3'h0) s = '{1'b1, 1'b1, 1'b0};
        if (n == 3'h1) s = '{1'b1, 1'b0, 1'b0};
      end
      TWLSG_SIG_DAT_HI:
      begin
        if (n == 3'h0) s = '{1'b1, 1'b0, 1'b1};
      end
      TWLSG_SIG_DAT_LO:
      begin
        if (n == 3'h0) s = '{1'b1, 1'b0, 1'b0};
      end
      TWLSG_SIG_CLK_HI:
      begin
        if (n == 3'h0) s = '{1'b1, 1'b1, 1'b1};
      end
      TWLSG_SIG_CLK_LO:
      begin
        if (n == 3'h0) s = '{1'b1, 1'b1, 1'b0};
      end
      default:
      begin
        s = 3'h0; // read types and unknown codes move no line
      end
    endcase
    return s;
  endfunction

  // command sequencer
  always_comb
  begin
    twlsg_step_t cur;
    cur               = step_of(st_reg.sig, st_reg.step);
    st_next           = st_reg;
    st_next.rsp_valid = 1'b0;
    st_next.reject    = 1'b0;
    unique case (st_reg.state)
      TWLSG_IDLE:
      begin
        if (i_cmd_valid && st_reg.ready)
        begin
          st_next.ready = 1'b0;
          if (i_cmd_opcode == TWLSG_OPCODE)
          begin
            st_next.sig   = i_cmd_signal;
            st_next.step  = TWLSG_STEP_RST;
            st_next.state = TWLSG_RUN;
          end
          else
          begin
            st_next.reject = 1'b1;
            st_next.ready  = 1'b1;
          end
        end
      end
      TWLSG_RUN:
      begin
        if (cur.valid)
        begin
          // apply one line step, then hold it
          if (cur.is_clk)
          begin
            st_next.clk_rel = cur.level;
          end
          else
          begin
            st_next.dat_rel = cur.level;
          end
          st_next.cnt   = TWLSG_CNT_RST;
          st_next.state = TWLSG_HOLD;
        end
        else
        begin
          st_next.state = TWLSG_DONE;
        end
      end
      TWLSG_HOLD:
      begin
        if (st_reg.cnt >= HOLD_LAST)
        begin
          st_next.step  = st_reg.step + 3'h1;
          st_next.state = TWLSG_RUN;
        end
        else
        begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
      end
      TWLSG_DONE:
      begin
        // answer: echo opcode, sampled line for read types, else zero
        st_next.rsp_valid  = 1'b1;
        st_next.rsp_opcode = TWLSG_OPCODE;
        if (st_reg.sig == TWLSG_SIG_RD_DAT)
        begin
          st_next.rsp_data = {7'h00, dat_level};
        end
        else if (st_reg.sig == TWLSG_SIG_RD_CLK)
        begin
          st_next.rsp_data = {7'h00, clk_level};
        end
        else
        begin
          st_next.rsp_data = 8'h00;
        end
        st_next.ready = 1'b1;
        st_next.state = TWLSG_IDLE;
      end
    endcase
  end

  // state register; lines start released, bus idle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      st_reg            <= '0;
      st_reg.state      <= TWLSG_IDLE;
      st_reg.dat_rel    <= 1'b1;
      st_reg.clk_rel    <= 1'b1;
      st_reg.ready      <= 1'b1;
      st_reg.rsp_opcode <= TWLSG_OPCODE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // open-drain drive: output always low, enable active low while pulling
  assign o_serial_data_pin       = 1'b0;
  assign o_serial_data_pin_oe_n  = st_reg.dat_rel;
  assign o_serial_clock_pin      = 1'b0;
  assign o_serial_clock_pin_oe_n = st_reg.clk_rel;
  assign o_cmd_ready             = st_reg.ready;
  assign o_rsp_valid             = st_reg.rsp_valid;
  assign o_rsp_opcode            = st_reg.rsp_opcode;
  assign o_rsp_data              = st_reg.rsp_data;
  assign o_cmd_reject            = st_reg.reject;
endmodule
`default_nettype wire

// ---- tb/twlsg_props.sv ----
// checker on the line signal generator ports
`timescale 1ns/1ns
`default_nettype none
module twlsg_props
#(
  parameter int P_STEP_CYCLES = 2
)
(
  input wire logic       i_ref_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_cmd_valid,
  input wire logic [7:0] i_cmd_opcode,
  input wire logic [7:0] i_cmd_signal,
  input wire logic       o_cmd_ready,
  input wire logic       o_rsp_valid,
  input wire logic [7:0] o_rsp_opcode,
  input wire logic [7:0] o_rsp_data,
  input wire logic       o_cmd_reject,
  input wire logic       o_serial_data_pin,
  input wire logic       o_serial_data_pin_oe_n,
  input wire logic       o_serial_clock_pin,
  input wire logic       o_serial_clock_pin_oe_n
);
  localparam int STEP = P_STEP_CYCLES + 1;
  localparam int START_LO = 1 + 4 * STEP;
  localparam int START_HI = 3 + 4 * STEP;
  localparam int STOP_LO = 1 + 3 * STEP;
  localparam int STOP_HI = 3 + 3 * STEP;
  // sample points inside a pattern: after the first step, mid start, mid stop
  localparam int FIRST_AT = 2;
  localparam int START_MID = 2 + 2 * STEP;
  localparam int STOP_MID = 2 + STEP;
  logic        take;
  logic        good;
  logic [1:0]  oe_prev_reg;
  logic [15:0] gap_reg;
  assign take = i_cmd_valid && o_cmd_ready;
  assign good = take && i_cmd_opcode == 8'h18;
  // cycles since either line last changed, saturating
  always_ff @(posedge i_ref_clk)
  begin
    oe_prev_reg <= {o_serial_data_pin_oe_n, o_serial_clock_pin_oe_n};
    if (i_sys_rst)
      gap_reg <= 16'hffff;
    else if (oe_prev_reg != {o_serial_data_pin_oe_n, o_serial_clock_pin_oe_n})
      gap_reg <= 16'h0000;
    else if (gap_reg != 16'hffff)
      gap_reg <= gap_reg + 16'h0001;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  drive_low_only_a: assert property (!o_serial_data_pin && !o_serial_clock_pin)
    else $error("line output driven high");
  rsp_echo_a: assert property (o_rsp_valid |-> o_rsp_opcode == 8'h18 && o_rsp_data[7:1] == 7'h00)
    else $error("answer opcode or data wrong");
  bad_opcode_a: assert property (take && i_cmd_opcode != 8'h18 |-> ##[1:2] o_cmd_reject ##1 !o_cmd_reject)
    else $error("bad opcode not rejected");
  busy_ready_a: assert property (good |-> ##[1:2] !o_cmd_ready)
    else $error("ready stays high while busy");
  start_seq_a: assert property (good && i_cmd_signal == 8'h01 |-> ##[START_LO:START_HI]
    (o_rsp_valid && !o_serial_data_pin_oe_n && !o_serial_clock_pin_oe_n)) else $error("start pattern wrong");
  stop_seq_a: assert property (good && i_cmd_signal == 8'h02 |-> ##[STOP_LO:STOP_HI]
    (o_rsp_valid && o_serial_data_pin_oe_n && o_serial_clock_pin_oe_n)) else $error("stop pattern wrong");
  step_hold_a: assert property ($changed(o_serial_data_pin_oe_n) || $changed(o_serial_clock_pin_oe_n)
    |-> gap_reg >= P_STEP_CYCLES) else $error("line step too short");
  bad_code_rsp_a: assert property (good && i_cmd_signal > 8'h0a |-> ##[1:3] (o_rsp_valid && o_rsp_data == 8'h00))
    else $error("unknown code answer wrong");
  init_data_first_a: assert property (good && i_cmd_signal == 8'h00 |-> ##FIRST_AT o_serial_data_pin_oe_n)
    else $error("init did not release data first");
  start_order_a: assert property (good && i_cmd_signal == 8'h01 |-> ##START_MID
    (!o_serial_data_pin_oe_n && o_serial_clock_pin_oe_n)) else $error("start: data did not fall with clock high");
  stop_order_a: assert property (good && i_cmd_signal == 8'h02 |-> ##STOP_MID
    (!o_serial_data_pin_oe_n && o_serial_clock_pin_oe_n)) else $error("stop: clock not high while data low");
  both_low_first_a: assert property (good && i_cmd_signal == 8'h03 |-> ##FIRST_AT !o_serial_clock_pin_oe_n)
    else $error("both low did not pull clock first");
  bad_code_lines_a: assert property (good && i_cmd_signal > 8'h0a
    |=> ($stable(o_serial_data_pin_oe_n) && $stable(o_serial_clock_pin_oe_n))[*3]) else $error("unknown code moved a line");
endmodule
bind twlsg_top twlsg_props #(.P_STEP_CYCLES(P_STEP_CYCLES)) u_twlsg_props (.i_ref_clk, .i_sys_rst, .i_cmd_valid,
  .i_cmd_opcode, .i_cmd_signal, .o_cmd_ready, .o_rsp_valid, .o_rsp_opcode, .o_rsp_data, .o_cmd_reject,
  .o_serial_data_pin, .o_serial_data_pin_oe_n, .o_serial_clock_pin, .o_serial_clock_pin_oe_n);
`default_nettype wire

// ---- tb/twlsg_slave_model.sv ----
// pull-up bus with a far-side device that can hold either line low
`timescale 1ns/1ns
`default_nettype none
module twlsg_slave_model
(
  input  wire logic i_data_oe_n,
  input  wire logic i_data_out,
  input  wire logic i_clock_oe_n,
  input  wire logic i_clock_out,
  input  wire logic i_pull_data,
  input  wire logic i_pull_clock,
  output logic      o_data_line,
  output logic      o_clock_line
);
  // a released line floats high unless the far device holds it
  assign o_data_line  = (i_data_oe_n ? 1'b1 : i_data_out) & ~i_pull_data;
  assign o_clock_line = (i_clock_oe_n ? 1'b1 : i_clock_out) & ~i_pull_clock;
endmodule
`default_nettype wire

// ---- tb/twlsg_top_test.sv ----
// self-checking bench for the line signal generator
`timescale 1ns/1ns
`default_nettype none
module twlsg_top_test;
  logic        clk = 1'b0, rst = 1'b1, valid = 1'b0, pull_d = 1'b0, pull_c = 1'b0;
  logic [7:0]  op = 8'h18, sig = 8'h00, rsp_op, rsp_dat;
  logic        ready, rsp_v, rej, d_pin, c_pin, d_out, c_out, d_oe_n, c_oe_n, rd;
  logic        exp_d = 1'b1, exp_c = 1'b1;
  logic [17:0] exp_q[$];
  int          err_total = 0, tests_run = 0, n_rsp = 0, n_rej = 0;
  integer      seed = 37404;
  always #5 clk = ~clk;
  twlsg_top #(.P_STEP_CYCLES(2)) u_twlsg_top (.i_ref_clk(clk), .i_sys_rst(rst), .i_cmd_valid(valid),
    .i_cmd_opcode(op), .i_cmd_signal(sig), .o_cmd_ready(ready), .o_rsp_valid(rsp_v), .o_rsp_opcode(rsp_op),
    .o_rsp_data(rsp_dat), .o_cmd_reject(rej), .i_serial_data_pin(d_pin), .o_serial_data_pin(d_out),
    .o_serial_data_pin_oe_n(d_oe_n), .i_serial_clock_pin(c_pin), .o_serial_clock_pin(c_out),
    .o_serial_clock_pin_oe_n(c_oe_n));
  twlsg_slave_model u_twlsg_slave_model (.i_data_oe_n(d_oe_n), .i_data_out(d_out), .i_clock_oe_n(c_oe_n),
    .i_clock_out(c_out), .i_pull_data(pull_d), .i_pull_clock(pull_c), .o_data_line(d_pin), .o_clock_line(c_pin));
  task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // count answers and rejects at the falling edge, where outputs are settled
  always @(negedge clk)
  begin
    if (rej === 1'b1)
      n_rej++;
    if (rsp_v === 1'b1)
    begin
      n_rsp++;
      if (exp_q.size() == 0)
        check("stray answer", 18'h00000, 18'h3ffff);
      else
        check("answer", exp_q.pop_front(), {rsp_op, rsp_dat, d_oe_n, c_oe_n});
    end
  end
  // present one command, note its expected answer, wait for the outcome
  task automatic send(input logic [7:0] o, input logic [7:0] s);
    int k, j, n;
    k = n_rsp;
    j = n_rej;
    n = 0;
    if (o == 8'h18)
    begin
      case (s)
        8'h00, 8'h02, 8'h04: {exp_d, exp_c} = 2'b11;
        8'h01, 8'h03: {exp_d, exp_c} = 2'b00;
        8'h05: exp_d = 1'b1;
        8'h06: exp_d = 1'b0;
        8'h07: exp_c = 1'b1;
        8'h08: exp_c = 1'b0;
        default: ;
      endcase
      rd = s == 8'h09 ? exp_d & ~pull_d : s == 8'h0a ? exp_c & ~pull_c : 1'b0;
      exp_q.push_back({8'h18, 7'h00, rd, exp_d, exp_c});
    end
    @(negedge clk);
    valid = 1'b1;
    op = o;
    sig = s;
    while (ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    valid = 1'b0;
    for (int i = 0; i < 40 && n_rsp == k && n_rej == j; i++)
      @(negedge clk);
    check("outcome", {16'h0000, o != 8'h18, o == 8'h18}, {16'h0000, 1'(n_rej - j), 1'(n_rsp - k)});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // every signal type twice with random far-side holds, then bad codes and opcodes
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 22; i++)
    begin
      pull_d = 1'($random(seed));
      pull_c = 1'($random(seed));
      repeat (6) @(negedge clk);
      send(8'h18, 8'(i % 11));
    end
    repeat (4) send(8'h18, 8'h0b + 8'(7'($random(seed))));
    send(8'h18 ^ 8'($random(seed) | 1), 8'h01);
    send(8'h18, 8'h0a);
    report_and_stop();
  end
  // cut a hang short
  initial
  begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
